/* rtl/eecc_channel.sv */
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ns
module eecc_channel
   import eecc_pkg::*;
#(
   parameter int CHANNEL = 1,
   parameter int CW = 16
)
(
   input wire logic sys_clk, // system clock, 250 MHz
   input wire logic resetn, // async reset, active low
   input wire logic [7:0] addr, // register byte address
   input wire logic [31:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [31:0] rdata, // read data, cycle after rd
   input wire logic ext_count_clk, // external count clock
   input wire logic phase_pin_a_ch1, // phase pin a, channel 1
   input wire logic phase_pin_b_ch1, // phase pin b, channel 1
   input wire logic phase_pin_a_ch2, // phase pin a, channel 2
   input wire logic phase_pin_b_ch2, // phase pin b, channel 2
   output logic compare_output_pin, // compare output
   output logic adc_start, // a/d start request pulse
   output logic irq // level interrupt
);
   localparam bit PHASE_OK = (CHANNEL == 1) || (CHANNEL == 2);
   localparam logic [CW-1:0] CMAX = {CW{1'b1}};

   logic ck_rise, ck_fall;
   logic a1_lvl, a1_rise, a1_fall, b1_lvl, b1_rise, b1_fall;
   logic a2_lvl, a2_rise, a2_fall, b2_lvl, b2_rise, b2_fall;

   // every external pin passes its own synchroniser first
   eecc_sync_edge u_ck (.sys_clk(sys_clk), .resetn(resetn), .pin(ext_count_clk),
      .level(), .rise(ck_rise), .fall(ck_fall));
   eecc_sync_edge u_a1 (.sys_clk(sys_clk), .resetn(resetn), .pin(phase_pin_a_ch1),
      .level(a1_lvl), .rise(a1_rise), .fall(a1_fall));
   eecc_sync_edge u_b1 (.sys_clk(sys_clk), .resetn(resetn), .pin(phase_pin_b_ch1),
      .level(b1_lvl), .rise(b1_rise), .fall(b1_fall));
   eecc_sync_edge u_a2 (.sys_clk(sys_clk), .resetn(resetn), .pin(phase_pin_a_ch2),
      .level(a2_lvl), .rise(a2_rise), .fall(a2_fall));
   eecc_sync_edge u_b2 (.sys_clk(sys_clk), .resetn(resetn), .pin(phase_pin_b_ch2),
      .level(b2_lvl), .rise(b2_rise), .fall(b2_fall));

   logic [EECC_CTRL_W-1:0] ctrl, next_ctrl;
   logic [CW-1:0] compare, next_compare;
   logic [CW-1:0] count, next_count;
   logic [EECC_ST_W-1:0] status, next_status;
   logic [EECC_ST_W-1:0] irq_en, next_irq_en;
   logic [31:0] next_rdata;
   logic next_pin, next_adc, next_irq;

   eecc_mode_t mode;
   eecc_edge_t edge_sel;
   eecc_phase_t ph_mode;
   eecc_act_t act;
   logic run, adc_en;
   assign mode = eecc_mode_t'(ctrl[EECC_CTRL_MODE_LSB +: 2]);
   assign edge_sel = eecc_edge_t'(ctrl[EECC_CTRL_EDGE_LSB +: 2]);
   assign ph_mode = eecc_phase_t'(ctrl[EECC_CTRL_PHASE_LSB +: 2]);
   assign act = eecc_act_t'(ctrl[EECC_CTRL_ACT_LSB +: 2]);
   assign adc_en = ctrl[EECC_CTRL_ADC_BIT];
   assign run = ctrl[EECC_CTRL_RUN_BIT];

   // pick the pin pair belonging to this channel
   logic pa, pa_r, pa_f, pb, pb_r, pb_f;
   assign pa = (CHANNEL == 2) ? a2_lvl : a1_lvl;
   assign pa_r = (CHANNEL == 2) ? a2_rise : a1_rise;
   assign pa_f = (CHANNEL == 2) ? a2_fall : a1_fall;
   assign pb = (CHANNEL == 2) ? b2_lvl : b1_lvl;
   assign pb_r = (CHANNEL == 2) ? b2_rise : b1_rise;
   assign pb_f = (CHANNEL == 2) ? b2_fall : b1_fall;

   logic cnt_evt, ph_up, ph_dn, up, dn, match_evt;
   logic ovf_evt, unf_evt, wr_hit;

   always_comb
   begin
      case (edge_sel)
         EECC_RISE: cnt_evt = ck_rise;
         EECC_FALL: cnt_evt = ck_fall;
         EECC_BOTH: cnt_evt = ck_rise | ck_fall;
         default: cnt_evt = 1'b0;
      endcase
      // sub-mode decode; a clash of up and down counts up
      case (ph_mode)
         EECC_PH1:
         begin
            ph_up = (pa & pb_r) | (~pa & pb_f) | (pa_r & ~pb) | (pa_f & pb);
            ph_dn = (pa & pb_f) | (~pa & pb_r) | (pa_r & pb) | (pa_f & ~pb);
         end
         EECC_PH2:
         begin
            ph_up = pa_f;
            ph_dn = 1'b0;
         end
         EECC_PH3:
         begin
            ph_up = pa_f & pb;
            ph_dn = pa & pb_f;
         end
         default:
         begin
            ph_up = (pa & pb_r) | (~pa & pb_f);
            ph_dn = (pa & pb_f) | (~pa & pb_r);
         end
      endcase
   end

   always_comb
   begin
      up = 1'b0;
      dn = 1'b0;
      match_evt = 1'b0;
      ovf_evt = 1'b0;
      unf_evt = 1'b0;
      next_count = count;
      wr_hit = wr && (addr == EECC_OFS_COUNT);
      if (run)
      begin
         case (mode)
            EECC_FREE:
               up = cnt_evt;
            EECC_PERIODIC:
            begin
               match_evt = cnt_evt && (count == compare);
               up = cnt_evt && !match_evt;
            end
            EECC_PHASE:
            begin
               up = PHASE_OK && ph_up;
               dn = PHASE_OK && ph_dn && !ph_up;
            end
            default: ;
         endcase
      end
      ovf_evt = up && (count == CMAX);
      unf_evt = dn && (count == '0);
      if (match_evt)
         next_count = '0;
      else if (up)
         next_count = count + 1'b1;
      else if (dn)
         next_count = count - 1'b1;
      // software load loses to nothing else in the same cycle
      if (wr_hit)
         next_count = wdata[CW-1:0];
   end

   always_comb
   begin
      next_ctrl = ctrl;
      next_compare = compare;
      next_irq_en = irq_en;
      next_status = status;
      if (wr && addr == EECC_OFS_CTRL)
         next_ctrl = wdata[EECC_CTRL_W-1:0];
      if (wr && addr == EECC_OFS_COMPARE)
         next_compare = wdata[CW-1:0];
      if (wr && addr == EECC_OFS_IRQ_EN)
         next_irq_en = wdata[EECC_ST_W-1:0];
      if (wr && addr == EECC_OFS_CLEAR)
         next_status = status & ~wdata[EECC_ST_W-1:0];
      // a new event beats a clear in the same cycle
      next_status[EECC_ST_OVF] = next_status[EECC_ST_OVF] | ovf_evt;
      next_status[EECC_ST_UNF] = next_status[EECC_ST_UNF] | unf_evt;
      next_status[EECC_ST_MATCH] = next_status[EECC_ST_MATCH] | match_evt;
      next_irq = |(next_status & next_irq_en);
      // pin rests at its initial level while not counting periodically;
      // a ctrl write reloads it, so a new initial level shows at once
      next_pin = compare_output_pin;
      if (!(run && mode == EECC_PERIODIC) || (wr && addr == EECC_OFS_CTRL))
         next_pin = next_ctrl[EECC_CTRL_INIT_BIT];
      else if (match_evt)
      begin
         case (act)
            EECC_OUT0: next_pin = 1'b0;
            EECC_OUT1: next_pin = 1'b1;
            EECC_TOGGLE: next_pin = ~compare_output_pin;
            default: next_pin = compare_output_pin;
         endcase
      end
      next_adc = match_evt && adc_en;
      next_rdata = 32'h0000_0000;
      if (rd)
      begin
         case (addr)
            EECC_OFS_CTRL: next_rdata[EECC_CTRL_W-1:0] = ctrl;
            EECC_OFS_COMPARE: next_rdata[CW-1:0] = compare;
            EECC_OFS_COUNT: next_rdata[CW-1:0] = count;
            EECC_OFS_STATUS: next_rdata[EECC_ST_W-1:0] = status;
            EECC_OFS_IRQ_EN: next_rdata[EECC_ST_W-1:0] = irq_en;
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl <= EECC_CTRL_RST;
         compare <= EECC_CNT_RST[CW-1:0];
         count <= EECC_CNT_RST[CW-1:0];
         status <= EECC_ST_RST;
         irq_en <= EECC_ST_RST;
         rdata <= 32'h0000_0000;
         compare_output_pin <= 1'b0;
         adc_start <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         ctrl <= next_ctrl;
         compare <= next_compare;
         count <= next_count;
         status <= next_status;
         irq_en <= next_irq_en;
         rdata <= next_rdata;
         compare_output_pin <= next_pin;
         adc_start <= next_adc;
         irq <= next_irq;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   a_evt_incr: assert property (run && mode == EECC_FREE && cnt_evt && count != CMAX && !wr
      |=> count == $past(count) + 1'b1) else $error("count did not step on edge");
   a_free_wrap: assert property (run && mode == EECC_FREE && cnt_evt && count == CMAX && !wr
      |=> count == '0 && status[EECC_ST_OVF]) else $error("free wrap wrong");
   a_per_clear: assert property (run && mode == EECC_PERIODIC && cnt_evt && count == compare
      && !wr |=> count == '0) else $error("periodic clear missing");
   a_match_flag: assert property (match_evt |=> status[EECC_ST_MATCH] ##1 1'b1)
      else $error("match flag not set");
   a_phase_gate: assert property (!PHASE_OK && mode == EECC_PHASE && !wr
      |=> $stable(count)) else $error("phase count on wrong channel");
   a_phase_under: assert property (run && mode == EECC_PHASE && PHASE_OK && dn && count == '0
      && !wr |=> count == CMAX && status[EECC_ST_UNF]) else $error("underflow wrong");
   a_ph2_noddown: assert property (run && mode == EECC_PHASE && ph_mode == EECC_PH2 && !wr
      |=> count == $past(count) || count == $past(count) + 1'b1)
      else $error("mode 2 moved down");
   a_pin_toggle: assert property (match_evt && act == EECC_TOGGLE && !wr
      |=> compare_output_pin != $past(compare_output_pin))
      else $error("pin did not toggle");
   a_adc_req: assert property (adc_start |-> $past(match_evt) && $past(adc_en))
      else $error("stray a/d start");
   a_sync_lat: assert property ($rose(ext_count_clk) ##1 ext_count_clk ##1 ext_count_clk
      |-> ck_rise) else $error("edge not seen two cycles later");
   a_irq_level: assert property (irq == |(status & irq_en))
      else $error("irq level mismatch");
   a_set_wins: assert property (ovf_evt && wr && addr == EECC_OFS_CLEAR
      |=> status[EECC_ST_OVF]) else $error("clear beat event");

   c_free_ovf: cover property (ovf_evt && mode == EECC_FREE);
   c_per_match: cover property (match_evt ##[1:20] match_evt);
   c_phase_unf: cover property (unf_evt);
   c_adc: cover property (adc_start);
endmodule

/* common/eecc_pkg.sv */
package eecc_pkg;
   // register byte offsets
   localparam logic [7:0] EECC_OFS_CTRL = 8'h00;
   localparam logic [7:0] EECC_OFS_COMPARE = 8'h04;
   localparam logic [7:0] EECC_OFS_COUNT = 8'h08;
   localparam logic [7:0] EECC_OFS_STATUS = 8'h0C;
   localparam logic [7:0] EECC_OFS_CLEAR = 8'h10;
   localparam logic [7:0] EECC_OFS_IRQ_EN = 8'h14;
   // control field positions
   localparam int EECC_CTRL_MODE_LSB = 0;
   localparam int EECC_CTRL_EDGE_LSB = 2;
   localparam int EECC_CTRL_PHASE_LSB = 4;
   localparam int EECC_CTRL_INIT_BIT = 6;
   localparam int EECC_CTRL_ACT_LSB = 7;
   localparam int EECC_CTRL_ADC_BIT = 9;
   localparam int EECC_CTRL_RUN_BIT = 10;
   localparam int EECC_CTRL_W = 11;
   localparam logic [10:0] EECC_CTRL_RST = 11'h000;
   // status / clear / enable bit positions
   localparam int EECC_ST_OVF = 0;
   localparam int EECC_ST_UNF = 1;
   localparam int EECC_ST_MATCH = 2;
   localparam int EECC_ST_W = 3;
   localparam logic [2:0] EECC_ST_RST = 3'h0;
   localparam logic [31:0] EECC_CNT_RST = 32'h0000_0000;

   typedef enum logic [1:0] {EECC_FREE, EECC_PERIODIC, EECC_PHASE, EECC_IDLE} eecc_mode_t;
   typedef enum logic [1:0] {EECC_RISE, EECC_FALL, EECC_BOTH, EECC_NONE} eecc_edge_t;
   typedef enum logic [1:0] {EECC_PH1, EECC_PH2, EECC_PH3, EECC_PH4} eecc_phase_t;
   typedef enum logic [1:0] {EECC_OUT0, EECC_OUT1, EECC_TOGGLE, EECC_KEEP} eecc_act_t;
endpackage

/* rtl/eecc_sync_edge.sv */
`timescale 1ns/1ns
module eecc_sync_edge
   import eecc_pkg::*;
(
   input wire logic sys_clk, // system clock
   input wire logic resetn, // async reset, active low
   input wire logic pin, // raw external pin
   output logic level, // synchronised level
   output logic rise, // one-cycle rising edge pulse
   output logic fall // one-cycle falling edge pulse
);
   logic meta;
   logic sync;
   logic last;

   // meta feeds only sync, never the edge logic
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         meta <= 1'b0;
         sync <= 1'b0;
         last <= 1'b0;
      end
      else
      begin
         meta <= pin;
         sync <= meta;
         last <= sync;
      end
   end

   assign level = sync;
   assign rise = sync & ~last;
   assign fall = ~sync & last;
endmodule

/* tb/eecc_src_model.sv */
`timescale 1ns/1ns
module eecc_src_model
(
   input wire logic sys_clk, // system clock
   output logic ext_count_clk, // external count clock
   output logic phase_pin_a_ch1, // channel 1 pin a
   output logic phase_pin_b_ch1, // channel 1 pin b
   output logic phase_pin_a_ch2, // channel 2 pin a
   output logic phase_pin_b_ch2 // channel 2 pin b
);
   initial
   begin
      ext_count_clk = 1'b0;
      {phase_pin_a_ch1, phase_pin_b_ch1} = 2'h0;
      {phase_pin_a_ch2, phase_pin_b_ch2} = 2'h0;
   end
   // v = {count clock, a1, b1}; each level held at least 7 cycles, well over the minimum
   task automatic set_pins(input logic [2:0] v);
      @(posedge sys_clk);
      ext_count_clk <= v[2];
      {phase_pin_a_ch1, phase_pin_b_ch1} <= v[1:0];
      // second pair gets a and b swapped, so it counts the other way except in EECC_PH2, where both pairs count up
      {phase_pin_a_ch2, phase_pin_b_ch2} <= {v[0], v[1]};
      repeat (6) @(posedge sys_clk);
   endtask
endmodule

/* tb/eecc_channel_tb_top.sv */
`timescale 1ns/1ns
module eecc_channel_tb_top;
   import eecc_pkg::*;
   logic sys_clk;
   logic resetn;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic wr;
   logic rd;
   logic [31:0] rdata;
   logic [31:0] rdata_2;
   logic [31:0] rdata_0;
   logic ext_count_clk;
   logic phase_pin_a_ch1;
   logic phase_pin_b_ch1;
   logic phase_pin_a_ch2;
   logic phase_pin_b_ch2;
   logic compare_output_pin;
   logic adc_start;
   logic irq;
   int errors;
   int checks_done;
   int adc_n;
   eecc_channel #(.CHANNEL(1), .CW(16)) u_eecc_channel (.sys_clk(sys_clk), .resetn(resetn),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .ext_count_clk(ext_count_clk), .phase_pin_a_ch1(phase_pin_a_ch1),
      .phase_pin_b_ch1(phase_pin_b_ch1), .phase_pin_a_ch2(phase_pin_a_ch2),
      .phase_pin_b_ch2(phase_pin_b_ch2), .compare_output_pin(compare_output_pin),
      .adc_start(adc_start), .irq(irq));
   // channel 2 uses the second pair; channel 0 offers no phase counting
   eecc_channel #(.CHANNEL(2), .CW(16)) u_eecc_channel_2 (.sys_clk(sys_clk), .resetn(resetn),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata_2),
      .ext_count_clk(ext_count_clk), .phase_pin_a_ch1(phase_pin_a_ch1),
      .phase_pin_b_ch1(phase_pin_b_ch1), .phase_pin_a_ch2(phase_pin_a_ch2),
      .phase_pin_b_ch2(phase_pin_b_ch2), .compare_output_pin(), .adc_start(), .irq());
   eecc_channel #(.CHANNEL(0), .CW(16)) u_eecc_channel_0 (.sys_clk(sys_clk), .resetn(resetn),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata_0),
      .ext_count_clk(ext_count_clk), .phase_pin_a_ch1(phase_pin_a_ch1),
      .phase_pin_b_ch1(phase_pin_b_ch1), .phase_pin_a_ch2(phase_pin_a_ch2),
      .phase_pin_b_ch2(phase_pin_b_ch2), .compare_output_pin(), .adc_start(), .irq());
   eecc_src_model u_eecc_src_model (.sys_clk(sys_clk), .ext_count_clk(ext_count_clk),
      .phase_pin_a_ch1(phase_pin_a_ch1), .phase_pin_b_ch1(phase_pin_b_ch1),
      .phase_pin_a_ch2(phase_pin_a_ch2), .phase_pin_b_ch2(phase_pin_b_ch2));
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      if (adc_start === 1'b1)
         adc_n++;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask
   function automatic logic [31:0] ctrl(input logic [1:0] m, input logic [1:0] p,
      input logic i, input logic [1:0] act, input logic c, input logic r);
      ctrl = 32'h0;
      ctrl[EECC_CTRL_MODE_LSB +: 2] = m;
      ctrl[EECC_CTRL_EDGE_LSB +: 2] = EECC_RISE;
      ctrl[EECC_CTRL_PHASE_LSB +: 2] = p;
      ctrl[EECC_CTRL_INIT_BIT] = i;
      ctrl[EECC_CTRL_ACT_LSB +: 2] = act;
      ctrl[EECC_CTRL_ADC_BIT] = c;
      ctrl[EECC_CTRL_RUN_BIT] = r;
   endfunction
   task automatic t_free();
      rd_chk(EECC_OFS_STATUS, 32'h0);
      rd_chk(8'h20, 32'h0);
      wr_reg(EECC_OFS_COUNT, 32'h0000FFFF);
      wr_reg(EECC_OFS_IRQ_EN, 32'h00000001);
      wr_reg(EECC_OFS_CTRL, ctrl(EECC_FREE, EECC_PH1, 1'b0, EECC_KEEP, 1'b0, 1'b1));
      u_eecc_src_model.set_pins(3'h4);
      rd_chk(EECC_OFS_COUNT, 32'h0);
      rd_chk(EECC_OFS_STATUS, 32'h1);
      chk({31'h0, irq}, 32'h1);
      u_eecc_src_model.set_pins(3'h0);
      rd_chk(EECC_OFS_COUNT, 32'h0);
      wr_reg(EECC_OFS_CLEAR, 32'h7);
      rd_chk(EECC_OFS_STATUS, 32'h0);
      chk({31'h0, irq}, 32'h0);
      $display("test free done");
   endtask
   // three rises with compare 2: counts 1, 2, then the match clears to 0
   task automatic t_periodic(input logic i, input logic [1:0] act, input logic c,
      input logic pin_exp, input int adc_exp);
      wr_reg(EECC_OFS_COMPARE, 32'h2);
      wr_reg(EECC_OFS_CTRL, ctrl(EECC_PERIODIC, EECC_PH1, i, act, c, 1'b1));
      adc_n = 0;
      #1;
      chk({31'h0, compare_output_pin}, {31'h0, i});
      for (int k = 1; k <= 3; k++)
      begin
         u_eecc_src_model.set_pins(3'h4);
         u_eecc_src_model.set_pins(3'h0);
         rd_chk(EECC_OFS_COUNT, (k % 3));
      end
      rd_chk(EECC_OFS_STATUS, 32'h4);
      chk({31'h0, compare_output_pin}, {31'h0, pin_exp});
      chk(adc_n, adc_exp);
      wr_reg(EECC_OFS_CLEAR, 32'h7);
      $display("test periodic done");
   endtask
   task automatic t_phase();
      wr_reg(EECC_OFS_COUNT, 32'h0);
      wr_reg(EECC_OFS_CTRL, ctrl(EECC_PHASE, EECC_PH1, 1'b0, EECC_KEEP, 1'b0, 1'b1));
      u_eecc_src_model.set_pins(3'h1);
      rd_chk(EECC_OFS_COUNT, 32'h0000FFFF);
      chk(rdata_2, 32'h1);
      chk(rdata_0, 32'h0);
      rd_chk(EECC_OFS_STATUS, 32'h2);
      chk(rdata_2, 32'h0);
      u_eecc_src_model.set_pins(3'h0);
      rd_chk(EECC_OFS_STATUS, 32'h3);
      u_eecc_src_model.set_pins(3'h2);
      rd_chk(EECC_OFS_COUNT, 32'h1);
      chk(rdata_2, 32'h0000FFFF);
      chk(rdata_0, 32'h0);
      wr_reg(EECC_OFS_CLEAR, 32'h7);
      u_eecc_src_model.set_pins(3'h0);
      // run off: pins must be ignored
      wr_reg(EECC_OFS_CTRL, ctrl(EECC_FREE, EECC_PH1, 1'b0, EECC_KEEP, 1'b0, 1'b0));
      u_eecc_src_model.set_pins(3'h4);
      rd_chk(EECC_OFS_COUNT, 32'h0);
      chk(rdata_2, 32'h0);
      u_eecc_src_model.set_pins(3'h0);
      $display("test phase done");
   endtask
   // forward walk a,b = 00,10,11,01,00 then the reverse walk, from count 0x10
   task automatic t_submode(input logic [1:0] p, input logic [31:0] fwd,
      input logic [31:0] rev);
      wr_reg(EECC_OFS_COUNT, 32'h10);
      wr_reg(EECC_OFS_CTRL, ctrl(EECC_PHASE, p, 1'b0, EECC_KEEP, 1'b0, 1'b1));
      u_eecc_src_model.set_pins(3'h2);
      u_eecc_src_model.set_pins(3'h3);
      u_eecc_src_model.set_pins(3'h1);
      u_eecc_src_model.set_pins(3'h0);
      rd_chk(EECC_OFS_COUNT, fwd);
      u_eecc_src_model.set_pins(3'h1);
      u_eecc_src_model.set_pins(3'h3);
      u_eecc_src_model.set_pins(3'h2);
      u_eecc_src_model.set_pins(3'h0);
      rd_chk(EECC_OFS_COUNT, rev);
      $display("test submode done");
   endtask
   // falling, both and no edge selected, one full count clock pulse each
   task automatic t_edges();
      wr_reg(EECC_OFS_COUNT, 32'h0);
      wr_reg(EECC_OFS_CTRL, ctrl(EECC_FREE, EECC_PH1, 1'b0, EECC_KEEP, 1'b0, 1'b1)
         | (32'(EECC_FALL) << EECC_CTRL_EDGE_LSB));
      u_eecc_src_model.set_pins(3'h4);
      rd_chk(EECC_OFS_COUNT, 32'h0);
      u_eecc_src_model.set_pins(3'h0);
      rd_chk(EECC_OFS_COUNT, 32'h1);
      wr_reg(EECC_OFS_CTRL, ctrl(EECC_FREE, EECC_PH1, 1'b0, EECC_KEEP, 1'b0, 1'b1)
         | (32'(EECC_BOTH) << EECC_CTRL_EDGE_LSB));
      u_eecc_src_model.set_pins(3'h4);
      u_eecc_src_model.set_pins(3'h0);
      rd_chk(EECC_OFS_COUNT, 32'h3);
      wr_reg(EECC_OFS_CTRL, ctrl(EECC_FREE, EECC_PH1, 1'b0, EECC_KEEP, 1'b0, 1'b1)
         | (32'(EECC_NONE) << EECC_CTRL_EDGE_LSB));
      u_eecc_src_model.set_pins(3'h4);
      u_eecc_src_model.set_pins(3'h0);
      rd_chk(EECC_OFS_COUNT, 32'h3);
      $display("test edges done");
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      #40000;
      errors++;
      end_of_test();
   end
   initial
   begin
      errors = 0;
      checks_done = 0;
      adc_n = 0;
      resetn = 1'b0;
      addr = 8'h0;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      t_free();
      t_periodic(1'b1, EECC_TOGGLE, 1'b1, 1'b0, 1);
      t_periodic(1'b0, EECC_OUT1, 1'b0, 1'b1, 0);
      t_periodic(1'b1, EECC_OUT0, 1'b0, 1'b0, 0);
      t_phase();
      t_submode(EECC_PH2, 32'h11, 32'h12);
      t_submode(EECC_PH3, 32'h11, 32'h10);
      t_submode(EECC_PH4, 32'h12, 32'h10);
      t_edges();
      end_of_test();
   end
endmodule
